// file: hw/dkce_editor.sv
// keyboard, cursor and buffer editing logic of a display station
`timescale 1ns/10ps
`include "dkce_cfg.svh"
// ----------------------------------------
// What this block does
// R01: power-on nulls the buffer, cursor at location 0, one flag per location
// R02: host write sets cursor flag where word count equals loaded cursor address
// R03: disabled keyboard lights input-inhibited and only honours reset
// R04: disable on host io, program keys, restricted keys inhibited, check, cmd bit
// R05: restricted-key disable cleared by reset key, others by host unlock
// R06: inhibit when entry leaves cursor protected or on attribute, or insert full
// R07: inhibited: only cursor, program and function keys, minus the restricted four
// R08: host transfers and keyboard edits never run together
// R09: cursor keys act while inhibited, never while disabled
// R10: arrow and backspace keys move only the cursor, with row and column wrap
// R11: tab goes to next unprotected field start, 0 if unformatted, repeats 6/s
// R12: back tab goes to current field start or preceding one, 0 if unformatted
// R13: new line goes to next line with unprotected position, else 0
// R14: lock latches upper case until shift; shift upper only in unprotected field
// R15: function keys raise no attention identifier
// R16: erase to field end nulls cursor to field end with wrap, cursor unmoved
// R17: erase to field end on attribute or protected disables, nothing changes
// R18: erase input nulls unprotected positions, cursor to first unprotected or 0
// R19: insert mode lights lamp; keys insert at cursor shifting right to a null
// R20: attributes stay fixed, shift crosses rows, full field disables
// R21: insert key in protected field disables; other functions behave normally
// R22: reset key leaves insert mode and darkens its lamp
// R23: cursor addresses run 0000 to 01DF, 480 locations
// R24: attribute A0 protects, 80 unprotects; any attribute means formatted
// ----------------------------------------
module dkce_editor
  import dkce_pkg::*;
#(
  parameter int REPEAT_CYC = `DKCE_TAB_REPEAT_CYC
)
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic keyStrobe,
  input wire dkce_key_t keyCode,
  input wire logic [7:0] keyChar,
  input wire logic shiftHeld,
  input wire logic hostIoActive,
  input wire logic hostCursorLoad,
  input wire logic [8:0] hostCursorAddr,
  input wire logic hostWrStart,
  input wire logic hostWrValid,
  input wire logic [7:0] hostWrData,
  input wire logic hostCmdValid,
  input wire logic hostCmdImmediate,
  input wire logic [7:0] hostCmdModifier,
  input wire logic hostUnlock,
  input wire logic bufCheck,
  input wire logic [8:0] rdAddr,
  output logic hostReady,
  output logic [7:0] rdData,
  output logic rdCursor,
  output logic [8:0] cursorPos,
  output logic inputInhibitedLamp,
  output logic insertLamp,
  output logic shiftUpper,
  output logic kbdDisabled,
  output logic kbdInhibited,
  output logic attnValid,
  output dkce_key_t attnKey,
  output logic busy
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // R23 addresses wrap at 01DF
  function automatic logic [8:0] wrapInc(input logic [8:0] p);
    return (p == `DKCE_LAST_LOC) ? `DKCE_HOME : 9'(p + 9'h001);
  endfunction
  function automatic logic [8:0] wrapDec(input logic [8:0] p);
    return (p == `DKCE_HOME) ? `DKCE_LAST_LOC : 9'(p - 9'h001);
  endfunction
  function automatic logic [8:0] rowNext(input logic [8:0] p);
    logic [8:0] n;
    n = 9'(p - (p % `DKCE_ROW_LEN) + `DKCE_ROW_LEN);
    return (n > `DKCE_LAST_LOC) ? `DKCE_HOME : n;
  endfunction
  function automatic logic isAttr(input logic [7:0] d);
    return (d & `DKCE_ATTR_MASK) == `DKCE_ATTR_MARK;
  endfunction

  logic [7:0] mem [0:`DKCE_LOCS-1];
  logic [`DKCE_LOCS-1:0] attrVec, protVec, startVec, cursorFlag;
  logic lastProt, curProt, formatted;
  dkce_state_t state;
  dkce_key_t op, codeS1, codeS2;
  logic [8:0] scanPtr, scanCnt, firstPos, wordCount, cursorReg;
  logic [7:0] charS1, charS2, charHold;
  logic keyS1, keyS2, keyS3, shiftS1, shiftS2;
  logic firstFound, inhibit, lockOut, disResetOnly, disHost, insertMode, shiftLock;
  logic [20:0] rptCnt;

  // ----------------------------------------
  // field map
  // ----------------------------------------
  // R24 attribute decode
  always_comb
  begin
    lastProt = 1'b0;
    for (int i = 0; i < `DKCE_LOCS; i++)
      if (isAttr(mem[i])) lastProt = mem[i][`DKCE_PROT_BIT];
    curProt = lastProt;
    for (int i = 0; i < `DKCE_LOCS; i++)
    begin
      if (isAttr(mem[i])) curProt = mem[i][`DKCE_PROT_BIT];
      attrVec[i] = isAttr(mem[i]);
      protVec[i] = curProt;
    end
    for (int i = 0; i < `DKCE_LOCS; i++)
      startVec[i] = !attrVec[i] && !protVec[i] && attrVec[(i + `DKCE_LOCS - 1) % `DKCE_LOCS];
  end
  assign formatted = |attrVec;

  // ----------------------------------------
  // keyboard input sync and repeat
  // ----------------------------------------
  // keyS1 and keyS2 synchronise the strobe, keyS3 marks its edge; code and char travel with its first two
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      keyS1 <= 1'b0;
      keyS2 <= 1'b0;
      keyS3 <= 1'b0;
      shiftS1 <= 1'b0;
      shiftS2 <= 1'b0;
      codeS1 <= K_CHAR;
      codeS2 <= K_CHAR;
      charS1 <= 8'h00;
      charS2 <= 8'h00;
    end
    else
    begin
      keyS1 <= keyStrobe;
      keyS2 <= keyS1;
      keyS3 <= keyS2;
      shiftS1 <= shiftHeld;
      shiftS2 <= shiftS1;
      codeS1 <= keyCode;
      codeS2 <= codeS1;
      charS1 <= keyChar;
      charS2 <= charS1;
    end
  end

  logic repeatFire;
  assign repeatFire = keyS2 && codeS2 == K_TAB && rptCnt == 21'(REPEAT_CYC - 1);
  // R11 tab auto repeat
  always_ff @(posedge mclk)
  begin
    if (!rstn || !keyS2 || codeS2 != K_TAB || repeatFire)
      rptCnt <= 21'h000000;
    else
      rptCnt <= 21'(rptCnt + 21'h000001);
  end

  // ----------------------------------------
  // key qualification
  // ----------------------------------------
  logic keyEvt, idleKey, disabled, restricted, act, doReset, isProgKey, lastStep;
  logic curData, eofFail, insProt, insFull, setInhibit, setLock, hostTake;
  dkce_key_t code;
  assign code = codeS2;
  assign keyEvt = (keyS2 && !keyS3) || repeatFire;
  // R08 keys arriving during host io or a running edit are dropped
  assign idleKey = keyEvt && state == S_IDLE && !hostIoActive;
  assign disabled = disResetOnly || disHost || hostIoActive;
  assign restricted = code inside {K_CHAR, K_ATTN_ONE, K_CANCEL, K_ERASE_EOF, K_DELETE};
  assign isProgKey = code inside {K_ATTN_ONE, K_CANCEL, K_PA_OTHER};
  assign doReset = idleKey && code == K_RESET;
  // R03 R09 disabled drops all but reset
  // R07 inhibited refuses restricted keys
  assign act = idleKey && !disabled && !(inhibit && restricted) && code != K_RESET;
  assign lockOut = idleKey && !disabled && inhibit && restricted;
  assign curData = !attrVec[cursorPos] && !protVec[cursorPos];
  assign lastStep = scanCnt == `DKCE_LAST_LOC;
  assign eofFail = act && code == K_ERASE_EOF && !curData;
  assign insProt = act && code == K_CHAR && insertMode && !curData;
  assign insFull = state == S_WALK && op == K_CHAR && !(mem[scanPtr] == `DKCE_NULL
    && !attrVec[scanPtr]) && (attrVec[scanPtr] || lastStep);
  assign setInhibit = insFull || (act && code == K_CHAR && !insertMode
    && (!curData || attrVec[wrapInc(cursorPos)] || protVec[wrapInc(cursorPos)]));
  assign setLock = lockOut || eofFail || insProt || insFull;
  assign hostTake = hostReady && hostIoActive && hostWrValid;

  // ----------------------------------------
  // buffer and cursor engine
  // ----------------------------------------
  // one location per cycle keeps the field walk small at the cost of latency
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      // R01 power-on clear and home
      for (int i = 0; i < `DKCE_LOCS; i++)
        mem[i] <= `DKCE_NULL;
      cursorPos <= `DKCE_HOME;
      state <= S_IDLE;
      op <= K_CHAR;
      scanPtr <= `DKCE_HOME;
      scanCnt <= `DKCE_HOME;
      firstFound <= 1'b0;
      firstPos <= `DKCE_HOME;
      wordCount <= `DKCE_HOME;
      cursorReg <= `DKCE_HOME;
      charHold <= `DKCE_NULL;
    end
    else
    begin
      if (hostCursorLoad)
        cursorReg <= hostCursorAddr;
      if (hostWrStart)
        wordCount <= `DKCE_HOME;
      else if (hostTake)
      begin
        mem[wordCount] <= hostWrData;
        // R02 cursor follows the matching word
        if (wordCount == cursorReg)
          cursorPos <= wordCount;
        wordCount <= wrapInc(wordCount);
      end
      unique case (state)
        S_IDLE:
          if (act)
          begin
            op <= code;
            scanCnt <= `DKCE_HOME;
            firstFound <= 1'b0;
            charHold <= charS2;
            // R10 cursor-only moves with wrap
            unique case (code)
              K_UP: cursorPos <= (cursorPos >= `DKCE_ROW_LEN) ? 9'(cursorPos - `DKCE_ROW_LEN)
                : 9'(cursorPos + `DKCE_LOCS9 - `DKCE_ROW_LEN);
              // plain sum would run past 01DF on the last row
              K_DOWN: cursorPos <= (cursorPos < 9'(`DKCE_LOCS9 - `DKCE_ROW_LEN))
                ? 9'(cursorPos + `DKCE_ROW_LEN) : 9'(cursorPos + `DKCE_ROW_LEN - `DKCE_LOCS9);
              K_LEFT, K_BKSP: cursorPos <= wrapDec(cursorPos);
              K_RIGHT: cursorPos <= wrapInc(cursorPos);
              // R19 direct write when not inserting or cursor holds a null
              K_CHAR:
                if (curData && (!insertMode || mem[cursorPos] == `DKCE_NULL))
                begin
                  mem[cursorPos] <= charS2;
                  cursorPos <= wrapInc(cursorPos);
                end
                else if (curData)
                begin
                  state <= S_WALK;
                  scanPtr <= wrapInc(cursorPos);
                end
              // R11 R12 unformatted goes home
              K_TAB, K_BTAB:
                if (!formatted)
                  cursorPos <= `DKCE_HOME;
                else
                begin
                  state <= S_WALK;
                  scanPtr <= (code == K_TAB) ? wrapInc(cursorPos) : wrapDec(cursorPos);
                end
              // R13 new line
              K_NEWLINE:
                if (!formatted)
                  cursorPos <= rowNext(cursorPos);
                else
                begin
                  state <= S_WALK;
                  scanPtr <= rowNext(cursorPos);
                end
              // R17 bad position leaves everything alone
              K_ERASE_EOF:
                if (curData)
                begin
                  state <= S_WALK;
                  scanPtr <= cursorPos;
                end
              K_ERASE_INPUT:
              begin
                state <= S_WALK;
                scanPtr <= `DKCE_HOME;
              end
              default: ;
            endcase
          end
        S_WALK:
        begin
          scanCnt <= 9'(scanCnt + 9'h001);
          scanPtr <= (op == K_BTAB) ? wrapDec(scanPtr) : wrapInc(scanPtr);
          unique case (op)
            // R11 R12 field start search
            K_TAB, K_BTAB:
              if (startVec[scanPtr] || lastStep)
              begin
                state <= S_IDLE;
                cursorPos <= startVec[scanPtr] ? scanPtr : `DKCE_HOME;
              end
            // R13 first unprotected position from next row
            K_NEWLINE:
              if ((!attrVec[scanPtr] && !protVec[scanPtr]) || lastStep)
              begin
                state <= S_IDLE;
                cursorPos <= (!attrVec[scanPtr] && !protVec[scanPtr]) ? scanPtr : `DKCE_HOME;
              end
            // R16 null to field end, cursor kept
            K_ERASE_EOF:
              if (attrVec[scanPtr])
                state <= S_IDLE;
              else
              begin
                mem[scanPtr] <= `DKCE_NULL;
                if (lastStep)
                  state <= S_IDLE;
              end
            // R18 erase every unprotected position
            K_ERASE_INPUT:
            begin
              if (!attrVec[scanPtr] && !protVec[scanPtr])
              begin
                mem[scanPtr] <= `DKCE_NULL;
                if (!firstFound)
                  firstPos <= scanPtr;
                firstFound <= 1'b1;
              end
              if (lastStep)
              begin
                state <= S_IDLE;
                cursorPos <= firstFound ? firstPos
                  : ((!attrVec[scanPtr] && !protVec[scanPtr]) ? scanPtr : `DKCE_HOME);
              end
            end
            // R20 null search stops at the field's attribute
            K_CHAR:
              if (mem[scanPtr] == `DKCE_NULL && !attrVec[scanPtr])
              begin
                state <= S_SHIFT;
                scanPtr <= scanPtr;
              end
              else if (attrVec[scanPtr] || lastStep)
                state <= S_IDLE;
            default: state <= S_IDLE;
          endcase
        end
        // R19 R20 shift right into the null, crossing rows linearly
        S_SHIFT:
          if (scanPtr == cursorPos)
          begin
            mem[scanPtr] <= charHold;
            cursorPos <= wrapInc(cursorPos);
            state <= S_IDLE;
          end
          else
          begin
            mem[scanPtr] <= mem[wrapDec(scanPtr)];
            scanPtr <= wrapDec(scanPtr);
          end
      endcase
    end
  end

  // ----------------------------------------
  // keyboard state flags
  // ----------------------------------------
  // R04 R05 R17 R20 R21 reset-key disable, set beats clear
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      disResetOnly <= 1'b0;
    else if (setLock)
      disResetOnly <= 1'b1;
    else if (doReset)
      disResetOnly <= 1'b0;
  end

  // R04 R05 program-cleared disable
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      disHost <= 1'b0;
    else if ((hostCmdValid && !hostCmdImmediate && hostCmdModifier[`DKCE_MOD_LOCK_BIT])
      || bufCheck || (act && isProgKey))
      disHost <= 1'b1;
    else if (hostUnlock)
      disHost <= 1'b0;
  end

  // R06 inhibit
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      inhibit <= 1'b0;
    else if (setInhibit)
      inhibit <= 1'b1;
    else if (doReset)
      inhibit <= 1'b0;
  end

  // R19 R22 insert mode
  always_ff @(posedge mclk)
  begin
    if (!rstn || doReset)
      insertMode <= 1'b0;
    else if (act && code == K_INSERT)
      insertMode <= 1'b1;
  end

  // R14 shift lock
  always_ff @(posedge mclk)
  begin
    if (!rstn || (act && code == K_SHIFT))
      shiftLock <= 1'b0;
    else if (act && code == K_LOCK)
      shiftLock <= 1'b1;
  end

  // R15 attention only from program keys
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      attnValid <= 1'b0;
      attnKey <= K_CHAR;
    end
    else
    begin
      attnValid <= act && isProgKey;
      if (act && isProgKey)
        attnKey <= code;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      cursorFlag <= '0;
      hostReady <= 1'b0;
      rdData <= `DKCE_NULL;
      rdCursor <= 1'b0;
      inputInhibitedLamp <= 1'b0;
      insertLamp <= 1'b0;
      shiftUpper <= 1'b0;
      kbdDisabled <= 1'b0;
      kbdInhibited <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < `DKCE_LOCS; i++)
        cursorFlag[i] <= (9'(i) == cursorPos);
      // R08 ready only once edits are idle
      hostReady <= hostIoActive && state == S_IDLE;
      rdData <= (rdAddr <= `DKCE_LAST_LOC) ? mem[rdAddr] : `DKCE_NULL;
      rdCursor <= (rdAddr <= `DKCE_LAST_LOC) && cursorFlag[rdAddr];
      // R03 lamp follows disable
      inputInhibitedLamp <= disabled;
      insertLamp <= insertMode;
      shiftUpper <= shiftLock || (shiftS2 && !protVec[cursorPos]);
      kbdDisabled <= disabled;
      kbdInhibited <= inhibit;
      busy <= state != S_IDLE;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_home; $rose(rstn) |-> cursorPos == `DKCE_HOME && !formatted; endproperty
  a_home: assert property (p_home) else $error("cursor not home after reset"); // R01
  property p_host_cursor; hostTake && wordCount == cursorReg && !hostWrStart
    |=> cursorPos == $past(wordCount); endproperty
  a_host_cursor: assert property (p_host_cursor) else $error("cursor flag missed"); // R02
  property p_lamp; disabled |=> inputInhibitedLamp; endproperty
  a_lamp: assert property (p_lamp) else $error("inhibit lamp dark"); // R03
  property p_check; bufCheck |=> disHost ##1 kbdDisabled; endproperty
  a_check: assert property (p_check) else $error("check did not disable"); // R04
  property p_hold; disResetOnly && !doReset |=> disResetOnly; endproperty
  a_hold: assert property (p_hold) else $error("lock cleared without reset"); // R05
  property p_full; insFull |=> inhibit && disResetOnly; endproperty
  a_full: assert property (p_full) else $error("full insert not inhibited"); // R06
  property p_excl; hostIoActive && state == S_IDLE |=> state == S_IDLE; endproperty
  a_excl: assert property (p_excl) else $error("edit ran during host io"); // R08
  property p_dis_move; keyEvt && disabled && code == K_RIGHT |=> $stable(cursorPos)
    || $past(hostTake); endproperty
  a_dis_move: assert property (p_dis_move) else $error("cursor moved while disabled"); // R09
  property p_right; act && code == K_RIGHT |=> cursorPos == wrapInc($past(cursorPos)); endproperty
  a_right: assert property (p_right) else $error("right key wrong"); // R10
  property p_no_attn; act && !isProgKey |=> !attnValid; endproperty
  a_no_attn: assert property (p_no_attn) else $error("function key raised attention"); // R15
  property p_eof_bad; eofFail |=> $stable(cursorPos) && disResetOnly && state == S_IDLE;
  endproperty
  a_eof_bad: assert property (p_eof_bad) else $error("bad erase acted"); // R17
  property p_ins_off; doReset |=> !insertMode ##1 !insertLamp; endproperty
  a_ins_off: assert property (p_ins_off) else $error("insert survived reset key"); // R22
  c_tab: cover property (act && code == K_TAB && formatted ##[1:480] state == S_IDLE);
  c_shift: cover property (state == S_SHIFT ##1 state == S_SHIFT);
  c_lock: cover property (lockOut ##[1:20] doReset);
endmodule

// file: hw/dkce_cfg.svh
// constants for the keyboard and cursor editor
`ifndef DKCE_CFG_SVH
`define DKCE_CFG_SVH
`define DKCE_LOCS 480
`define DKCE_LOCS9 9'h1E0
`define DKCE_LAST_LOC 9'h1DF
`define DKCE_HOME 9'h000
`define DKCE_ROW_LEN 9'h028
`define DKCE_NULL 8'h00
`define DKCE_ATTR_MASK 8'hC0
`define DKCE_ATTR_MARK 8'h80
`define DKCE_ATTR_PROT 8'hA0
`define DKCE_ATTR_UNPROT 8'h80
`define DKCE_PROT_BIT 5
`define DKCE_MOD_LOCK_BIT 0
`define DKCE_CLK_HZ 10000000
`define DKCE_TAB_RATE_HZ 6
`define DKCE_TAB_REPEAT_CYC (`DKCE_CLK_HZ / `DKCE_TAB_RATE_HZ)
`endif

// file: hw/dkce_pkg.sv
// types for the keyboard and cursor editor
package dkce_pkg;
  typedef enum logic [4:0] {K_CHAR, K_UP, K_DOWN, K_LEFT, K_RIGHT, K_BKSP, K_TAB, K_BTAB,
    K_NEWLINE, K_SHIFT, K_LOCK, K_ERASE_EOF, K_ERASE_INPUT, K_INSERT, K_RESET,
    K_ATTN_ONE, K_CANCEL, K_PA_OTHER, K_DELETE} dkce_key_t;
  typedef enum logic [1:0] {S_IDLE, S_WALK, S_SHIFT} dkce_state_t;
endpackage

// file: tb/dkce_host_model.sv
// host attachment model issuing start-io buffer transfers
`timescale 1ns/10ps
module dkce_host_model
(
  input wire logic mclk,
  input wire logic hostReady,
  output logic hostIoActive,
  output logic hostCursorLoad,
  output logic [8:0] hostCursorAddr,
  output logic hostWrStart,
  output logic hostWrValid,
  output logic [7:0] hostWrData,
  output logic hostCmdValid,
  output logic hostCmdImmediate,
  output logic [7:0] hostCmdModifier,
  output logic hostUnlock,
  output logic bufCheck
);
  initial {hostIoActive, hostCursorLoad, hostCursorAddr, hostWrStart, hostWrValid} = '0;
  initial {hostWrData, hostCmdValid, hostCmdImmediate, hostCmdModifier, hostUnlock, bufCheck} = '0;
  task automatic write_screen(input logic [7:0] img [480], input logic [8:0] addr);
    @(posedge mclk) #1 hostIoActive = 1'b1;
    hostCursorAddr = addr;
    hostCursorLoad = 1'b1;
    @(posedge mclk) #1 hostCursorLoad = 1'b0;
    hostCursorAddr = ~addr;
    for (int n = 0; n < 20 && hostReady !== 1'b1; n++) @(posedge mclk);
    @(posedge mclk) #1 hostWrStart = 1'b1;
    @(posedge mclk) #1 hostWrStart = 1'b0;
    for (int i = 0; i < 480; i++)
    begin
      hostWrValid = 1'b1;
      hostWrData = img[i];
      do @(posedge mclk); while (hostReady !== 1'b1);
      #1;
    end
    hostWrValid = 1'b0;
    // released bus shows no stale word
    hostWrData = ~hostWrData;
  endtask
  task automatic io_end;
    @(posedge mclk) #1 hostIoActive = 1'b0;
  endtask
  // program action: 0 command, 1 unlock, 2 check
  task automatic pulse(input int sel, input logic [7:0] mod, input logic imm);
    @(posedge mclk) #1;
    hostCmdModifier = mod;
    hostCmdImmediate = imm;
    hostCmdValid = (sel == 0);
    hostUnlock = (sel == 1);
    bufCheck = (sel == 2);
    @(posedge mclk) #1;
    {hostCmdValid, hostUnlock, bufCheck} = '0;
    hostCmdModifier = ~mod;
    repeat (3) @(posedge mclk);
    #1;
  endtask
endmodule

// file: tb/dkce_editor_test.sv
// self-checking bench for the keyboard and cursor editor
`timescale 1ns/10ps
module dkce_editor_test
  import dkce_pkg::*;
;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic keyStrobe = 1'b0;
  dkce_key_t keyCode = K_CHAR;
  logic [7:0] keyChar = 8'h00;
  logic shiftHeld = 1'b0;
  logic [8:0] rdAddr = 9'h000;
  logic hostIoActive, hostCursorLoad, hostWrStart, hostWrValid, hostCmdValid;
  logic hostCmdImmediate, hostUnlock, bufCheck, hostReady, rdCursor, inputInhibitedLamp;
  logic insertLamp, shiftUpper, kbdDisabled, kbdInhibited, attnValid, busy;
  logic [8:0] hostCursorAddr, cursorPos;
  logic [7:0] hostWrData, hostCmdModifier, rdData;
  dkce_key_t attnKey;
  int mismatches = 0;
  int num_checks = 0;
  int seed = 32'ha0d72460;
  int ec = 0;
  int ed = 0;
  int ei = 0;
  int ea = 0;
  int eh = 0;
  int attnCnt = 0;
  logic [7:0] m [480] = '{default: 8'h00};
  logic [7:0] img [480];
  always #50 mclk = ~mclk;
  always @(posedge mclk) if (attnValid === 1'b1) attnCnt <= attnCnt + 1;
  dkce_editor #(.REPEAT_CYC(8)) i_dut (.mclk(mclk), .rstn(rstn), .keyStrobe(keyStrobe),
    .keyCode(keyCode), .keyChar(keyChar), .shiftHeld(shiftHeld), .hostIoActive(hostIoActive),
    .hostCursorLoad(hostCursorLoad), .hostCursorAddr(hostCursorAddr), .hostWrStart(hostWrStart),
    .hostWrValid(hostWrValid), .hostWrData(hostWrData), .hostCmdValid(hostCmdValid),
    .hostCmdImmediate(hostCmdImmediate), .hostCmdModifier(hostCmdModifier),
    .hostUnlock(hostUnlock), .bufCheck(bufCheck), .rdAddr(rdAddr), .hostReady(hostReady),
    .rdData(rdData), .rdCursor(rdCursor), .cursorPos(cursorPos), .insertLamp(insertLamp),
    .inputInhibitedLamp(inputInhibitedLamp), .shiftUpper(shiftUpper), .busy(busy),
    .kbdDisabled(kbdDisabled), .kbdInhibited(kbdInhibited), .attnValid(attnValid),
    .attnKey(attnKey));
  dkce_host_model i_host (.mclk(mclk), .hostReady(hostReady), .hostIoActive(hostIoActive),
    .hostCursorLoad(hostCursorLoad), .hostCursorAddr(hostCursorAddr), .hostWrStart(hostWrStart),
    .hostWrValid(hostWrValid), .hostWrData(hostWrData), .hostCmdValid(hostCmdValid),
    .hostCmdImmediate(hostCmdImmediate), .hostCmdModifier(hostCmdModifier),
    .hostUnlock(hostUnlock), .bufCheck(bufCheck));
  // ----------------------------------------
  // reference model
  // ----------------------------------------
  function automatic bit isAttr(int a);
    return (m[a] & 8'hC0) == 8'h80;
  endfunction
  function automatic bit inProt(int a);
    for (int i = 0; i < 480; i++) if (isAttr((a + 480 - i) % 480)) return m[(a + 480 - i) % 480][5];
    return 1'b0;
  endfunction
  function automatic int nextTab(int a);
    for (int i = 1; i <= 480; i++) if (isAttr((a + i) % 480) && !m[(a + i) % 480][5]) return (a + i + 1) % 480;
    return 0;
  endfunction
  function automatic int firstUnprot();
    for (int j = 0; j < 480; j++) if (!isAttr(j) && !inProt(j)) return j;
    return 0;
  endfunction
  // ----------------------------------------
  // checks and key driver
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkall;
    for (int a = 0; a < 480; a++)
    begin
      @(posedge mclk) #1 rdAddr = 9'(a);
      @(posedge mclk) #1;
      chk(16'(rdData), 16'(m[a]));
      chk(16'(rdCursor), 16'(a == ec));
    end
    chk(16'(cursorPos), 16'(ec));
    chk(16'(kbdDisabled), 16'(ed != 0));
    chk(16'(inputInhibitedLamp), 16'(ed != 0));
    chk(16'(kbdInhibited), 16'(eh));
    chk(16'(insertLamp), 16'(ei));
    chk(16'(attnCnt), 16'(ea));
  endtask
  task automatic press(input dkce_key_t k, input logic [7:0] ch);
    int j;
    @(posedge mclk) #1 keyCode = k;
    keyChar = ch;
    repeat (2) @(posedge mclk);
    #1 keyStrobe = 1'b1;
    // short hold, so field skip never auto-repeats
    repeat (5) @(posedge mclk);
    #1 keyStrobe = 1'b0;
    for (int n = 0; n < 2000 && busy !== 1'b0; n++) @(posedge mclk);
    repeat (4) @(posedge mclk);
    if (ed == 0 || k == K_RESET)
      case (k)
        K_RIGHT: ec = (ec + 1) % 480;
        K_LEFT, K_BKSP: ec = (ec + 479) % 480;
        K_UP: ec = (ec + 440) % 480;
        K_DOWN: ec = (ec + 40) % 480;
        K_TAB: ec = nextTab(ec);
        K_ERASE_EOF: if (isAttr(ec) || inProt(ec)) ed = 1;
          else for (int j = ec; !isAttr(j); j = (j + 1) % 480) m[j] = 8'h00;
        K_ERASE_INPUT: ec = firstUnprot();
        K_ATTN_ONE: {ed, ea} = {ed | 32'd2, ea + 1};
        K_INSERT: ei = 1;
        K_CHAR:
        begin
          j = ec;
          while (ei && m[j] != 8'h00 && !isAttr(j)) j = (j + 1) % 480;
          if (isAttr(j)) {ed, eh} = {ed | 32'd1, 32'd1};
          else for (int i = j; i != ec; i = (i + 479) % 480) m[i] = m[(i + 479) % 480];
          if (!isAttr(j)) {m[ec], ec} = {ch, (ec + 1) % 480};
        end
        K_RESET: {ei, ed, eh} = {32'd0, ed & 32'd2, 32'd0};
        default: ;
      endcase
    chkall;
  endtask
  task automatic test_done;
    if (mismatches == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge mclk);
    mismatches++;
    test_done;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    for (int i = 0; i < 480; i++) img[i] = 8'h40 | 8'($random(seed) & 32'h3F);
    img[0] = 8'hA0;
    img[40] = 8'h80;
    img[80] = 8'hA0;
    repeat (16) @(posedge mclk);
    #1 rstn = 1'b1;
    chkall;
    i_host.write_screen(img, 9'h032);
    m = img;
    {ec, ed} = {32'd50, 32'd1};
    chkall;
    chk(16'(hostReady), 16'h0001);
    i_host.io_end();
    i_host.pulse(1, 8'h00, 1'b0);
    ed = 0;
    press(K_INSERT, 8'h00);
    press(K_CHAR, 8'h41);
    press(K_RESET, 8'h00);
    press(K_RIGHT, 8'h00);
    press(K_UP, 8'h00);
    press(K_UP, 8'h00);
    press(K_TAB, 8'h00);
    press(K_ERASE_EOF, 8'h00);
    press(K_DOWN, 8'h00);
    press(K_ERASE_EOF, 8'h00);
    press(K_RIGHT, 8'h00);
    i_host.pulse(1, 8'h00, 1'b0);
    chk(16'(kbdDisabled), 16'(ed != 0));
    press(K_RESET, 8'h00);
    press(K_ATTN_ONE, 8'h00);
    chk(16'(attnKey), 16'(K_ATTN_ONE));
    press(K_RESET, 8'h00);
    i_host.pulse(1, 8'h00, 1'b0);
    ed = 0;
    press(K_ERASE_INPUT, 8'h00);
    press(K_INSERT, 8'h00);
    press(K_CHAR, 8'h40 | 8'($random(seed) & 32'h3F));
    press(K_LEFT, 8'h00);
    press(K_CHAR, 8'h40 | 8'($random(seed) & 32'h3F));
    press(K_RESET, 8'h00);
    @(posedge mclk) #1 shiftHeld = 1'b1;
    repeat (6) @(posedge mclk);
    #1 chk(16'(shiftUpper), 16'h0001);
    press(K_DOWN, 8'h00);
    chk(16'(shiftUpper), 16'h0000);
    i_host.pulse(0, 8'h01, 1'b0);
    chk(16'(kbdDisabled), 16'h0001);
    i_host.pulse(1, 8'h00, 1'b0);
    i_host.pulse(0, 8'h01, 1'b1);
    chk(16'(kbdDisabled), 16'h0000);
    i_host.pulse(2, 8'h00, 1'b0);
    chk(16'(kbdDisabled), 16'h0001);
    i_host.pulse(1, 8'h00, 1'b0);
    chk(16'(kbdDisabled), 16'h0000);
    test_done;
  end
endmodule
